// File: hdl/ocfr_pkg.sv
// Package: constants for the overcurrent fault response register bank
package ocfr_pkg;
   localparam logic [7:0] OCFR_CMD_CODE = 8'h47;
   localparam logic [7:0] OCFR_RESET_VAL = 8'h3F;
   localparam logic [2:0] OCFR_DELAY_VAL = 3'h7;
   localparam int OCFR_SET_LSB = 3;
   localparam int OCFR_SET_MSB = 5;
   localparam logic [7:0] OCFR_PAGE_CH1 = 8'h00;
   localparam logic [7:0] OCFR_PAGE_CH2 = 8'h01;
   localparam logic [7:0] OCFR_PAGE_ALL = 8'hFF;
   localparam logic [2:0] OCFR_SET_DEFAULT = 3'h7;
   // Status bit positions inside each status register
   localparam int OCFR_SB_OCF_BIT = 4;
   localparam int OCFR_SB_CML_BIT = 1;
   localparam int OCFR_SW_IOUT_BIT = 14;
   localparam int OCFR_SI_OCF_BIT = 7;
   localparam int OCFR_SI_OCW_BIT = 5;
   localparam int OCFR_CML_IVC_BIT = 7;
endpackage

// File: hdl/ocfr_chan.sv
// Per-channel storage of the response setting field
`timescale 1ns/1ps
module ocfr_chan
   import ocfr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [2:0] load_val_i,
   input wire logic wr_i,
   input wire logic [2:0] wr_val_i,
   output logic [2:0] setting_o
);
   typedef struct packed
   {
      logic [2:0] setting;
   } ocfr_chan_st_t;

   ocfr_chan_st_t st_q;
   ocfr_chan_st_t st_d;

   always_comb
   begin
      st_d = st_q;
      if (load_i)
      begin
         st_d.setting = load_val_i;
      end
      else if (wr_i)
      begin
         st_d.setting = wr_val_i;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         st_q.setting <= OCFR_SET_DEFAULT;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign setting_o = st_q.setting;
endmodule

// File: hdl/ocfr_bank.sv
// Overcurrent fault response register bank with paging and fault flags
// Function
// [R1] The stored response setting of a channel drives its fault action.
// [R2] An overcurrent fault sets the overcurrent flag of the status byte.
// [R3] An overcurrent fault sets the overcurrent bits of the status word.
// [R4] An overcurrent fault sets fault and warning flags of output current.
// [R5] An overcurrent fault raises the alert line toward the host.
// [R6] Bits two to zero always read as 111, the fixed delay of seven units.
// [R7] Each channel has its own copy, page 0 selecting channel one.
// [R8] Writes on page 0 are always taken; a load_i in the same cycle drops the write, which is still acked.
// [R9] Writes to the page 1 copy are taken only while channel two is master.
// [R10] A slave channel two uses the page 0 setting.
// [R11] The host keeps stacked slave page 0 equal to the master; unchecked.
// [R12] A refused page 1 write is NACKed, flags invalid command and alerts.
// [R13] Power-up loads 00111111 unless a stored user value replaces it.
// [R14] Bits five to three are writable; bits seven and six read zero.
// [R15] Writes to read-only bits are dropped while writable bits are kept.
`timescale 1ns/1ps
module ocfr_bank
   import ocfr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [7:0] page_i,
   input wire logic ch2_master_i,
   input wire logic wr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_i,
   input wire logic load_i,
   input wire logic user_valid_i,
   input wire logic [7:0] user_val_i,
   input wire logic [1:0] oc_fault_i,
   input wire logic [1:0] uv_fault_i,
   input wire logic clear_faults_i,
   input wire logic alert_ack_i,
   output logic wr_ack_o,
   output logic wr_nack_o,
   output logic [7:0] rd_data_o,
   output logic [2:0] ch1_response_o,
   output logic [2:0] ch2_response_o,
   output logic [2:0] fault_delay_o,
   output logic [1:0] act_fire_o,
   output logic [7:0] status_byte_o,
   output logic [15:0] status_word_o,
   output logic [7:0] status_iout_o,
   output logic [7:0] status_cml_o,
   output logic smb_alert_n_o
);
   typedef struct packed
   {
      logic ack;
      logic nack;
      logic [7:0] rdata;
      logic [1:0] overcurrent_fault_flag;
      logic [1:0] overcurrent_warning_flag;
      logic invalid_command_flag;
      logic alert;
      logic [1:0] fire;
   } ocfr_st_t;

   ocfr_st_t st_q;
   ocfr_st_t st_d;
   logic [2:0] set1;
   logic [2:0] set2;
   logic [2:0] eff2;
   logic is_p0;
   logic is_p1;
   logic refuse;
   logic wr1;
   logic wr2;
   logic [2:0] ld_val;
   logic [2:0] wr_val;
   logic [7:0] sel_val;

   assign is_p0 = (page_i == OCFR_PAGE_CH1) || (page_i == OCFR_PAGE_ALL);
   assign is_p1 = (page_i == OCFR_PAGE_CH2) || (page_i == OCFR_PAGE_ALL);
   assign refuse = wr_i && (page_i == OCFR_PAGE_CH2) && !ch2_master_i; // [R12]
   assign wr1 = wr_i && is_p0; // [R8]
   assign wr2 = wr_i && is_p1 && ch2_master_i; // [R9]
   assign wr_val = wr_data_i[OCFR_SET_MSB:OCFR_SET_LSB]; // [R15]
   assign ld_val = user_valid_i ? user_val_i[OCFR_SET_MSB:OCFR_SET_LSB]
                                : OCFR_RESET_VAL[OCFR_SET_MSB:OCFR_SET_LSB];

   // Channel copies; page 0 is channel one [R7]
   ocfr_chan u_ch1
   (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .load_i(load_i), // [R13]
      .load_val_i(ld_val),
      .wr_i(wr1),
      .wr_val_i(wr_val),
      .setting_o(set1)
   );

   ocfr_chan u_ch2
   (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .load_i(load_i),
      .load_val_i(ld_val),
      .wr_i(wr2),
      .wr_val_i(wr_val),
      .setting_o(set2)
   );

   assign eff2 = ch2_master_i ? set2 : set1; // [R10]
   // Readback: bits 7:6 zero, 5:3 setting, 2:0 fixed delay [R14] [R6]
   assign sel_val = {2'h0, (page_i == OCFR_PAGE_CH2) ? eff2 : set1,
                     OCFR_DELAY_VAL};

   always_comb
   begin
      st_d = st_q;
      st_d.ack = (wr1 || wr2) && !refuse;
      st_d.nack = refuse; // [R12]
      if (rd_i)
      begin
         st_d.rdata = sel_val;
      end
      // Hardware set wins over clear in the same cycle
      if (clear_faults_i)
      begin
         st_d.overcurrent_fault_flag = 2'h0;
         st_d.overcurrent_warning_flag = 2'h0;
         st_d.invalid_command_flag = 1'b0;
      end
      st_d.overcurrent_fault_flag = st_d.overcurrent_fault_flag | oc_fault_i; // [R2] [R3] [R4]
      st_d.overcurrent_warning_flag = st_d.overcurrent_warning_flag | oc_fault_i; // [R4]
      st_d.invalid_command_flag = st_d.invalid_command_flag | refuse; // [R12]
      if (alert_ack_i || clear_faults_i)
      begin
         st_d.alert = 1'b0;
      end
      if ((|oc_fault_i) || refuse)
      begin
         st_d.alert = 1'b1; // [R5] [R12]
      end
      st_d.fire = oc_fault_i | uv_fault_i; // [R1]
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign wr_ack_o = st_q.ack;
   assign wr_nack_o = st_q.nack;
   assign rd_data_o = st_q.rdata;
   assign ch1_response_o = set1; // [R1]
   assign ch2_response_o = eff2;
   assign fault_delay_o = OCFR_DELAY_VAL; // [R6]
   assign act_fire_o = st_q.fire;

   always_comb
   begin
      status_byte_o = 8'h00;
      status_byte_o[OCFR_SB_OCF_BIT] = |st_q.overcurrent_fault_flag; // [R2]
      status_byte_o[OCFR_SB_CML_BIT] = st_q.invalid_command_flag;
      status_word_o = 16'h0000;
      status_word_o[7:0] = status_byte_o; // [R3]
      status_word_o[OCFR_SW_IOUT_BIT] = |st_q.overcurrent_fault_flag;
      status_iout_o = 8'h00;
      status_iout_o[OCFR_SI_OCF_BIT] = |st_q.overcurrent_fault_flag; // [R4]
      status_iout_o[OCFR_SI_OCW_BIT] = |st_q.overcurrent_warning_flag;
      status_cml_o = 8'h00;
      status_cml_o[OCFR_CML_IVC_BIT] = st_q.invalid_command_flag;
   end

   assign smb_alert_n_o = !st_q.alert; // [R5]

   property p_refuse_nack;
      @(posedge clk_sys_i) disable iff (reset_i)
      refuse |=> wr_nack_o && !wr_ack_o && status_cml_o[OCFR_CML_IVC_BIT]
         && !smb_alert_n_o;
   endproperty
   a_refuse_nack: assert property (p_refuse_nack) // [R12]
      else $error("refused write not nacked");

   property p_oc_flags;
      @(posedge clk_sys_i) disable iff (reset_i)
      (|oc_fault_i) |=> status_byte_o[OCFR_SB_OCF_BIT]
         && status_iout_o[OCFR_SI_OCF_BIT] && status_iout_o[OCFR_SI_OCW_BIT]
         && status_word_o[OCFR_SW_IOUT_BIT] && !smb_alert_n_o;
   endproperty
   a_oc_flags: assert property (p_oc_flags) // [R2] [R3] [R4] [R5]
      else $error("overcurrent flags not set");

   property p_delay_fixed;
      @(posedge clk_sys_i) disable iff (reset_i)
      rd_i |=> rd_data_o[OCFR_SET_LSB-1:0] == OCFR_DELAY_VAL
         && rd_data_o[7:OCFR_SET_MSB+1] == '0;
   endproperty
   a_delay_fixed: assert property (p_delay_fixed) // [R6]
      else $error("fixed bits wrong on read");

   property p_slave_follow;
      @(posedge clk_sys_i) disable iff (reset_i)
      !ch2_master_i |-> ch2_response_o == ch1_response_o;
   endproperty
   a_slave_follow: assert property (p_slave_follow) // [R10]
      else $error("slave channel not following page 0");

   property p_p0_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      (wr_i && page_i == OCFR_PAGE_CH1 && !load_i) |=>
         ch1_response_o == $past(wr_val) && wr_ack_o;
   endproperty
   a_p0_write: assert property (p_p0_write) // [R8]
      else $error("page 0 write not stored");

   property p_p1_keep;
      @(posedge clk_sys_i) disable iff (reset_i)
      (refuse && !load_i) |=> $stable(set2);
   endproperty
   a_p1_keep: assert property (p_p1_keep) // [R9]
      else $error("refused page 1 write changed copy");

   property p_load;
      @(posedge clk_sys_i) disable iff (reset_i)
      (load_i && !user_valid_i) |=>
         set1 == OCFR_SET_DEFAULT && set2 == OCFR_SET_DEFAULT;
   endproperty
   a_load: assert property (p_load) // [R13]
      else $error("default load wrong");

   property p_fire;
      @(posedge clk_sys_i) disable iff (reset_i)
      uv_fault_i[0] |=> act_fire_o[0];
   endproperty
   a_fire: assert property (p_fire) // [R1]
      else $error("fault action not fired");

   // A slave channel two must pick up a page 0 write, not a stale copy
   sequence s_slave_p0_write;
      !ch2_master_i && wr1 && !load_i;
   endsequence

   sequence s_still_slave;
      !ch2_master_i;
   endsequence

   property p_slave_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      s_slave_p0_write ##1 s_still_slave |->
         ch2_response_o == $past(wr_val);
   endproperty
   a_slave_write: assert property (p_slave_write) // [R10]
      else $error("slave channel missed page 0 write");

   sequence s_both_pages_master;
      wr_i && page_i == OCFR_PAGE_ALL && ch2_master_i && !load_i;
   endsequence

   property p_all_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      s_both_pages_master |=> set1 == $past(wr_val) && set2 == $past(wr_val);
   endproperty
   a_all_write: assert property (p_all_write) // [R9]
      else $error("both-page write not stored in both copies");

   // An acknowledge with no new event in the same cycle drops the alert
   sequence s_alert_ack_only;
      alert_ack_i && !(|oc_fault_i) && !refuse;
   endsequence

   property p_alert_ack;
      @(posedge clk_sys_i) disable iff (reset_i)
      s_alert_ack_only |=> smb_alert_n_o;
   endproperty
   a_alert_ack: assert property (p_alert_ack) // [R5]
      else $error("alert not released by acknowledge");
endmodule

// File: dv/ocfr_host_model.sv
// Host model issuing single-byte writes and reads to the response command
`timescale 1ns/1ps
module ocfr_host_model
(
   input wire logic clk_sys_i,
   input wire logic wr_ack_i,
   input wire logic wr_nack_i,
   input wire logic [7:0] rd_data_i,
   output logic [7:0] page_o = 8'h00,
   output logic wr_o = 1'b0,
   output logic [7:0] wr_data_o = 8'h00,
   output logic rd_o = 1'b0
);
   // One request per call; data byte inverted after release
   task automatic xfer(input logic [7:0] pg, input logic w,
      input logic [7:0] d, output logic [7:0] rv, output logic [1:0] an);
      @(posedge clk_sys_i);
      page_o <= pg;
      wr_data_o <= d;
      wr_o <= w;
      rd_o <= !w;
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      wr_data_o <= ~d;
      #1;
      an = {wr_ack_i, wr_nack_i};
      rv = rd_data_i;
   endtask
endmodule

// File: dv/ocfr_bank_tb_top.sv
// Self-checking bench for the overcurrent fault response bank
`timescale 1ns/1ps
module ocfr_bank_tb_top;
   import ocfr_pkg::*;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, ms = 1'b0, ld = 1'b0;
   logic uvl = 1'b0, clr = 1'b0, aack = 1'b0;
   logic [7:0] uval = 8'h00, page, wd, rdat, sb, si, sc, rv;
   logic [1:0] oc = 2'h0, uv = 2'h0, fire, an;
   logic wr, rd, ack, nack, al_n;
   logic [2:0] r1, r2, dly;
   logic [15:0] sw;
   int err_count = 0, cmp_count = 0, cyc = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   ocfr_bank u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .page_i(page),
      .ch2_master_i(ms), .wr_i(wr), .wr_data_i(wd), .rd_i(rd), .load_i(ld),
      .user_valid_i(uvl), .user_val_i(uval), .oc_fault_i(oc),
      .uv_fault_i(uv), .clear_faults_i(clr), .alert_ack_i(aack),
      .wr_ack_o(ack), .wr_nack_o(nack), .rd_data_o(rdat),
      .ch1_response_o(r1), .ch2_response_o(r2), .fault_delay_o(dly),
      .act_fire_o(fire), .status_byte_o(sb), .status_word_o(sw),
      .status_iout_o(si), .status_cml_o(sc), .smb_alert_n_o(al_n));
   ocfr_host_model u_host (.clk_sys_i(clk_sys_i), .wr_ack_i(ack),
      .wr_nack_i(nack), .rd_data_i(rdat), .page_o(page), .wr_o(wr),
      .wr_data_o(wd), .rd_o(rd));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic pulse_clear;
      @(posedge clk_sys_i);
      clr <= 1'b1;
      @(posedge clk_sys_i);
      clr <= 1'b0;
      #1;
      chk(al_n, 1'b1);
      chk({sb, sc}, 16'h0000);
   endtask
   task automatic t_mask;
      u_host.xfer(OCFR_PAGE_CH1, 1'b0, 8'h00, rv, an);
      chk(rv, OCFR_RESET_VAL);
      chk(dly, 3'h7);
      u_host.xfer(OCFR_PAGE_CH1, 1'b1, 8'hC0, rv, an);
      chk(an, 2'b10);
      chk(r1, 3'h0);
      chk(r2, 3'h0);
      u_host.xfer(OCFR_PAGE_CH1, 1'b0, 8'h00, rv, an);
      chk(rv, 8'h07);
   endtask
   task automatic t_refuse;
      // Stacked slave: page 0 programmed with the master's value
      u_host.xfer(OCFR_PAGE_CH1, 1'b1, 8'h00, rv, an);
      chk(an, 2'b10);
      u_host.xfer(OCFR_PAGE_CH2, 1'b1, 8'h28, rv, an);
      chk(an, 2'b01);
      chk(sc[OCFR_CML_IVC_BIT], 1'b1);
      chk(sb[OCFR_SB_CML_BIT], 1'b1);
      chk(al_n, 1'b0);
      chk(r2, 3'h0);
      pulse_clear();
   endtask
   task automatic t_master;
      @(posedge clk_sys_i);
      ms <= 1'b1;
      #1;
      chk(r2, OCFR_SET_DEFAULT);
      u_host.xfer(OCFR_PAGE_CH2, 1'b1, 8'h10, rv, an);
      chk(an, 2'b10);
      chk({r1, r2}, 6'o02);
      u_host.xfer(OCFR_PAGE_CH2, 1'b0, 8'h00, rv, an);
      chk(rv, 8'h17);
      u_host.xfer(OCFR_PAGE_CH1, 1'b0, 8'h00, rv, an);
      chk(rv, 8'h07);
   endtask
   task automatic t_all;
      u_host.xfer(OCFR_PAGE_ALL, 1'b1, 8'h18, rv, an);
      chk(an, 2'b10);
      chk({r1, r2}, 6'o33);
      @(posedge clk_sys_i);
      ms <= 1'b0;
      u_host.xfer(OCFR_PAGE_ALL, 1'b1, 8'h30, rv, an);
      chk(an, 2'b10);
      chk(r2, 3'h6);
      @(posedge clk_sys_i);
      ms <= 1'b1;
      #1;
      chk(r2, 3'h3);
      u_host.xfer(8'h02, 1'b1, 8'h08, rv, an);
      chk({an, r1}, 5'b00110);
   endtask
   task automatic t_ack;
      @(posedge clk_sys_i);
      oc <= 2'b10;
      @(posedge clk_sys_i);
      oc <= 2'b00;
      aack <= 1'b1;
      #1;
      chk(sw, 16'h4010);
      chk(al_n, 1'b0);
      @(posedge clk_sys_i);
      aack <= 1'b0;
      #1;
      chk(al_n, 1'b1);
      chk(si[OCFR_SI_OCF_BIT], 1'b1);
      pulse_clear();
   endtask
   task automatic t_reset;
      @(posedge clk_sys_i);
      oc <= 2'b11;
      @(posedge clk_sys_i);
      oc <= 2'b00;
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1;
      chk({r1, r2, dly}, 9'o777);
      chk({sb, si}, 16'h0000);
      chk({sc, rdat}, 16'h0000);
      chk(al_n, 1'b1);
   endtask
   task automatic t_fault;
      @(posedge clk_sys_i);
      oc <= 2'b01;
      @(posedge clk_sys_i);
      oc <= 2'b00;
      uv <= 2'b10;
      #1;
      chk(fire, 2'b01);
      chk(sb[OCFR_SB_OCF_BIT], 1'b1);
      chk(sw[OCFR_SW_IOUT_BIT], 1'b1);
      chk({si[OCFR_SI_OCF_BIT], si[OCFR_SI_OCW_BIT]}, 2'b11);
      chk(al_n, 1'b0);
      @(posedge clk_sys_i);
      uv <= 2'b00;
      #1;
      chk(fire, 2'b10);
      pulse_clear();
   endtask
   task automatic t_load(input logic v, input logic [7:0] e);
      @(posedge clk_sys_i);
      uvl <= v;
      uval <= 8'h20;
      ld <= 1'b1;
      @(posedge clk_sys_i);
      ld <= 1'b0;
      u_host.xfer(OCFR_PAGE_CH2, 1'b0, 8'h00, rv, an);
      chk(rv, e);
   endtask
   task conclude;
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Whole sequence needs well under a hundred cycles
   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         err_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_mask();
      t_refuse();
      t_master();
      t_all();
      t_fault();
      t_ack();
      t_reset();
      t_load(1'b1, 8'h27);
      t_load(1'b0, OCFR_RESET_VAL);
      conclude();
   end
endmodule
